// [src/plc_fifo2.sv]
module plc_fifo2 import plc_pkg::*; #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic wptr;
        logic rptr;
        logic [1:0] count;
    } plc_fifo_state_t;

    plc_fifo_state_t s_r;
    plc_fifo_state_t s_nxt;
    logic push;
    logic pop;

    assign in_ready = (s_r.count != 2'h2);
    assign out_valid = (s_r.count != 2'h0);
    assign out_data = s_r.mem[s_r.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wptr] = in_data;
            s_nxt.wptr = ~s_r.wptr;
        end
        if (pop) begin
            s_nxt.rptr = ~s_r.rptr;
        end
        if (push && !pop) begin
            s_nxt.count = s_r.count + 2'h1;
        end else if (pop && !push) begin
            s_nxt.count = s_r.count - 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    fifo_count_a: assert property (@(posedge mclk) disable iff (rst)
        s_r.count <= 2'h2)
        else $error("buffer count above two");
endmodule

// [src/plc_pkg.sv]
package plc_pkg;
    // Clock and carrier rates, in kHz, and clock cycles per microsecond
    localparam int unsigned PLC_CLK_KHZ = 250000;
    localparam int unsigned PLC_SYS_KHZ = 7680;
    localparam int unsigned PLC_CAR_MIN_KHZ = 118;
    localparam int unsigned PLC_CAR_MAX_KHZ = 122;
    localparam int unsigned PLC_CYC_PER_US = PLC_CLK_KHZ / 1000;
    // System-clock cycles per carrier half period
    localparam int unsigned PLC_HALF_SYS_CYC = 32;

    // Times in microseconds
    localparam int unsigned PLC_RISE_LAG_US = 64;
    localparam int unsigned PLC_FALL_LEAD_US = 16;
    localparam int unsigned PLC_START_MAX_US = 236;
    localparam int unsigned PLC_TX_FROM_TRUE_US = 214;
    localparam int unsigned PLC_SMP_FROM_TRUE_US = 500;
    localparam int unsigned PLC_BURST_US = 1000;
    localparam int unsigned PLC_PHASE_GAP_US = 2778;

    // Cycle counts at the clock rate
    localparam int unsigned PLC_TXD_RISE_CYC =
        (PLC_TX_FROM_TRUE_US - PLC_RISE_LAG_US) * PLC_CYC_PER_US;
    localparam int unsigned PLC_TXD_FALL_CYC =
        (PLC_TX_FROM_TRUE_US + PLC_FALL_LEAD_US) * PLC_CYC_PER_US;
    localparam int unsigned PLC_SMP_RISE_CYC =
        (PLC_SMP_FROM_TRUE_US - PLC_RISE_LAG_US) * PLC_CYC_PER_US;
    localparam int unsigned PLC_SMP_FALL_CYC =
        (PLC_SMP_FROM_TRUE_US + PLC_FALL_LEAD_US) * PLC_CYC_PER_US;
    localparam int unsigned PLC_BURST_CYC = PLC_BURST_US * PLC_CYC_PER_US;
    localparam int unsigned PLC_GAP_CYC = PLC_PHASE_GAP_US * PLC_CYC_PER_US;
    localparam int unsigned PLC_START_MAX_CYC = PLC_START_MAX_US * PLC_CYC_PER_US;
    localparam int unsigned PLC_PER_MIN_CYC =
        (PLC_CLK_KHZ + PLC_CAR_MAX_KHZ - 1) / PLC_CAR_MAX_KHZ;
    localparam int unsigned PLC_PER_MAX_CYC = PLC_CLK_KHZ / PLC_CAR_MIN_KHZ;

    // Counter widths and extra burst count
    localparam int unsigned PLC_CNT_W = 20;
    localparam int unsigned PLC_ACC_W = 18;
    localparam int unsigned PLC_EXTRA_BURSTS = 2;

    typedef enum logic [1:0] {
        PLC_ST_IDLE  = 2'b00,
        PLC_ST_DELAY = 2'b01,
        PLC_ST_BURST = 2'b10,
        PLC_ST_GAP   = 2'b11
    } plc_tx_state_t;
endpackage

// [src/plc_timing.sv]
module plc_timing import plc_pkg::*; #(
    parameter logic [19:0] TXD_RISE_CYC = 20'(PLC_TXD_RISE_CYC),
    parameter logic [19:0] TXD_FALL_CYC = 20'(PLC_TXD_FALL_CYC),
    parameter logic [19:0] SMP_RISE_CYC = 20'(PLC_SMP_RISE_CYC),
    parameter logic [19:0] SMP_FALL_CYC = 20'(PLC_SMP_FALL_CYC),
    parameter logic [19:0] BURST_CYC = 20'(PLC_BURST_CYC),
    parameter logic [19:0] GAP_CYC = 20'(PLC_GAP_CYC)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Mains crossing and carrier envelope sensing
    input wire logic crossing_sense_input,
    input wire logic carrier_envelope_input,
    output logic crossing_event,
    // Transmit bit request, one per crossing
    input wire logic tx_valid,
    input wire logic tx_bit,
    input wire logic tx_three_phase,
    output logic tx_ready,
    // Received bit stream
    output logic rx_valid,
    output logic rx_bit,
    input wire logic rx_ready,
    output logic rx_overrun,
    // Carrier line pin
    output logic carrier_line_o,
    output logic carrier_line_oe
);
    typedef struct packed {
        logic sense_prev;
        logic pol;
        logic armed;
        logic evt;
        plc_tx_state_t st;
        logic [PLC_CNT_W-1:0] cnt;
        logic [1:0] bursts;
        logic [PLC_CNT_W-1:0] smp_cnt;
        logic smp_pend;
        logic hold_v;
        logic hold_bit;
        logic overrun;
        logic [PLC_ACC_W-1:0] acc;
        logic [4:0] half;
        logic wave;
    } plc_state_t;

    localparam logic [PLC_ACC_W-1:0] ACC_STEP = PLC_ACC_W'(PLC_SYS_KHZ);
    localparam logic [PLC_ACC_W-1:0] ACC_MOD = PLC_ACC_W'(PLC_CLK_KHZ);
    localparam logic [4:0] HALF_LAST = 5'(PLC_HALF_SYS_CYC - 1);

    plc_state_t s_r;
    plc_state_t s_nxt;
    logic evt;
    logic sys_en;
    logic [PLC_ACC_W:0] acc_sum;
    logic fire;
    logic buf_ready;

    // The active edge is armed on the opposite level, so every level change once armed is an event
    assign evt = s_r.armed && (crossing_sense_input != s_r.sense_prev)
        && (crossing_sense_input == s_r.pol);
    assign fire = s_r.smp_pend && (s_r.smp_cnt == 20'h00001);
    assign acc_sum = {1'b0, s_r.acc} + {1'b0, ACC_STEP};
    // Fractional divider: 7.680 MHz enables on average from the 250 MHz clock
    assign sys_en = (acc_sum >= {1'b0, ACC_MOD});
    assign tx_ready = s_r.evt && (s_r.st == PLC_ST_IDLE);
    assign crossing_event = s_r.evt;
    assign rx_overrun = s_r.overrun;
    assign carrier_line_o = s_r.wave;
    assign carrier_line_oe = (s_r.st == PLC_ST_BURST);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sense_prev = crossing_sense_input;
        s_nxt.evt = evt;
        s_nxt.overrun = 1'b0;
        if (!s_r.armed) begin
            s_nxt.armed = 1'b1;
            s_nxt.pol = ~crossing_sense_input;
        end else if (evt) begin
            s_nxt.pol = ~s_r.pol;
        end

        // Carrier generator runs regardless of transmit state
        if (sys_en) begin
            s_nxt.acc = PLC_ACC_W'(acc_sum - {1'b0, ACC_MOD});
            if (s_r.half == HALF_LAST) begin
                s_nxt.half = 5'h00;
                s_nxt.wave = ~s_r.wave;
            end else begin
                s_nxt.half = s_r.half + 5'h01;
            end
        end else begin
            s_nxt.acc = PLC_ACC_W'(acc_sum);
        end

        // Receive: the sample point sits at a fixed time after the true crossing
        if (evt) begin
            s_nxt.smp_pend = 1'b1;
            s_nxt.smp_cnt = crossing_sense_input ? SMP_RISE_CYC : SMP_FALL_CYC;
        end else if (s_r.smp_pend) begin
            s_nxt.smp_cnt = s_r.smp_cnt - 20'h00001;
            if (fire) begin
                s_nxt.smp_pend = 1'b0;
            end
        end
        if (s_r.hold_v && buf_ready) begin
            s_nxt.hold_v = 1'b0;
        end
        // A new sample wins over the hand-off of the held one
        if (fire) begin
            s_nxt.hold_v = 1'b1;
            s_nxt.hold_bit = carrier_envelope_input;
            s_nxt.overrun = s_r.hold_v && !buf_ready;
        end

        // Envelope timer
        case (s_r.st)
            PLC_ST_IDLE: begin
                if (tx_ready && tx_valid && tx_bit) begin
                    s_nxt.st = PLC_ST_DELAY;
                    // Polarity has already flipped here; the sensed level names the edge
                    s_nxt.cnt = s_r.sense_prev ? TXD_RISE_CYC : TXD_FALL_CYC;
                    s_nxt.bursts = tx_three_phase ? 2'(PLC_EXTRA_BURSTS) : 2'h0;
                end
            end
            PLC_ST_DELAY: begin
                s_nxt.cnt = s_r.cnt - 20'h00001;
                if (s_r.cnt == 20'h00001) begin
                    s_nxt.st = PLC_ST_BURST;
                    s_nxt.cnt = BURST_CYC;
                end
            end
            PLC_ST_BURST: begin
                s_nxt.cnt = s_r.cnt - 20'h00001;
                if (s_r.cnt == 20'h00001) begin
                    if (s_r.bursts != 2'h0) begin
                        s_nxt.st = PLC_ST_GAP;
                        s_nxt.cnt = GAP_CYC - BURST_CYC;
                        s_nxt.bursts = s_r.bursts - 2'h1;
                    end else begin
                        s_nxt.st = PLC_ST_IDLE;
                    end
                end
            end
            PLC_ST_GAP: begin
                s_nxt.cnt = s_r.cnt - 20'h00001;
                if (s_r.cnt == 20'h00001) begin
                    s_nxt.st = PLC_ST_BURST;
                    s_nxt.cnt = BURST_CYC;
                end
            end
            default: begin
                s_nxt.st = PLC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Two entries plus the held bit: the receiver may stall about three bit times before overrun
    plc_fifo2 #(
        .WIDTH(1)
    ) u_rx_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(s_r.hold_v),
        .in_data(s_r.hold_bit),
        .in_ready(buf_ready),
        .out_valid(rx_valid),
        .out_data(rx_bit),
        .out_ready(rx_ready)
    );

    // Helper logic for checks
    localparam int unsigned START_MAX = PLC_START_MAX_CYC;
    localparam int unsigned WIN_MAX = PLC_BURST_CYC;
    logic [PLC_CNT_W-1:0] since_evt_r;
    logic [PLC_CNT_W-1:0] oe_len_r;
    logic [PLC_CNT_W-1:0] per_r;
    logic since_rise_r;
    logic wave_seen_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            since_evt_r <= '0;
            oe_len_r <= '0;
            per_r <= '0;
            since_rise_r <= 1'b0;
            wave_seen_r <= 1'b0;
        end else begin
            // The first rise after reset has no full period behind it
            if (s_nxt.wave && !s_r.wave) begin
                wave_seen_r <= 1'b1;
            end
            since_evt_r <= evt ? 20'h00000 : (&since_evt_r ? since_evt_r : since_evt_r + 20'h00001);
            if (evt) begin
                since_rise_r <= crossing_sense_input;
            end
            oe_len_r <= carrier_line_oe ? oe_len_r + 20'h00001 : 20'h00000;
            per_r <= (s_nxt.wave && !s_r.wave) ? 20'h00001 : per_r + 20'h00001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence seq_evt_taken;
        evt ##1 s_r.evt;
    endsequence

    edge_event_a: assert property (s_r.armed && s_r.sense_prev != crossing_sense_input
        |-> evt)
        else $error("crossing change without event");
    sense_level_a: assert property (s_r.armed |-> s_r.pol != s_r.sense_prev)
        else $error("armed edge not opposite to sensed level");
    edge_flip_a: assert property (seq_evt_taken |-> s_r.pol != $past(s_r.pol))
        else $error("edge polarity not inverted after event");
    start_bound_a: assert property ($rose(carrier_line_oe) && $past(s_r.st) == PLC_ST_DELAY
        |-> since_evt_r < START_MAX && since_evt_r ==
        (since_rise_r ? TXD_RISE_CYC : TXD_FALL_CYC) + 20'h00001)
        else $error("burst start delay wrong");
    burst_len_a: assert property ($fell(carrier_line_oe) |-> oe_len_r == BURST_CYC)
        else $error("burst length not 1 ms");
    sample_win_a: assert property (fire |-> since_evt_r < WIN_MAX)
        else $error("sample outside window");
    sample_bit_a: assert property (fire |=> s_r.hold_v && s_r.hold_bit ==
        $past(carrier_envelope_input))
        else $error("sampled bit not captured");
    carrier_free_a: assert property (carrier_line_o == s_r.wave
        && (s_r.st == PLC_ST_BURST) == carrier_line_oe)
        else $error("carrier pin not gated by direction");
    toggle_step_a: assert property ($changed(s_r.wave) |-> $past(sys_en)
        && $past(s_r.half) == HALF_LAST && s_r.half == 5'h00)
        else $error("carrier toggled off the 32-step boundary");
    carrier_freq_a: assert property ($rose(s_r.wave) && $past(wave_seen_r)
        |-> $past(per_r) >= 20'(PLC_PER_MIN_CYC)
        && $past(per_r) <= 20'(PLC_PER_MAX_CYC))
        else $error("carrier period out of range");
endmodule

// [verification/plc_mains_model.sv]
module plc_mains_model #(
    parameter int HALF = 1000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Carrier present or absent for each crossing, by crossing number
    input wire logic [31:0] pattern,
    // Line view seen by the device
    output logic sense = 1'b0,
    output logic envelope = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    int idx;

    // The envelope only changes at a crossing, so it is steady through each window
    always @(posedge mclk) begin
        if (rst) begin
            cnt <= 0;
            idx <= 0;
            sense <= 1'b0;
            envelope <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            sense <= ~sense;
            envelope <= pattern[idx % 32];
            idx <= idx + 1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// [verification/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import plc_pkg::*;
    localparam int TR = 20;
    localparam int TF = 30;
    localparam int BL = 100;
    localparam int GP = 300;
    logic mclk, rst, sense, env, ev, tx_valid, tx_bit, tx_three, tx_ready;
    logic rx_valid, rx_bit, rx_ready, rx_ovr, car_o, car_oe, oe_q, car_q, sense_q;
    logic [31:0] pattern;
    int seed = 32'h0C66106A;
    int error_cnt, num_checks, cyc, n_ev, n_tog, ovr_exp, ovr_seen, rise_cyc, d;
    int tog_cyc = -1;
    int exp_rx[$];
    int exp_rise[$];
    bit stall;

    plc_timing #(.TXD_RISE_CYC(20'(TR)), .TXD_FALL_CYC(20'(TF)), .SMP_RISE_CYC(20'h00028),
        .SMP_FALL_CYC(20'h00032), .BURST_CYC(20'(BL)), .GAP_CYC(20'(GP))) DUT (
        .mclk(mclk), .rst(rst), .crossing_sense_input(sense), .carrier_envelope_input(env),
        .crossing_event(ev), .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_three_phase(tx_three),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_ready(rx_ready),
        .rx_overrun(rx_ovr), .carrier_line_o(car_o), .carrier_line_oe(car_oe));
    plc_mains_model #(.HALF(1000)) line_model (.mclk(mclk), .rst(rst), .pattern(pattern),
        .sense(sense), .envelope(env));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", name, expv, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Reference model: runs on values sampled at each edge
    always @(posedge mclk) begin
        cyc++;
        if (ev === 1'b1) begin
            // Full buffer plus held bit: the newest sample replaces the held one
            if (stall && exp_rx.size() >= 3) begin
                exp_rx[exp_rx.size() - 1] = pattern[n_ev % 32];
                ovr_exp++;
            end else begin
                exp_rx.push_back(pattern[n_ev % 32]);
            end
            n_ev++;
            // Every burst train ends well before the next crossing, so the sender is idle
            check("tx_ready", tx_ready, 1);
            if (tx_bit === 1'b1) begin
                d = (sense === 1'b1) ? TR : TF;
                for (int k = 0; k < (tx_three ? 3 : 1); k++) begin
                    exp_rise.push_back(cyc + d + 1 + k * GP);
                end
            end
        end
        if (car_oe === 1'b1 && oe_q === 1'b0) begin
            rise_cyc = cyc;
            check("burst_start", cyc, exp_rise.size() ? exp_rise.pop_front() : -1);
        end
        if (car_oe === 1'b0 && oe_q === 1'b1) begin
            check("burst_len", cyc - rise_cyc, BL);
        end
        oe_q = car_oe;
        if (car_o !== car_q && rst === 1'b0) begin
            if (tog_cyc >= 0) begin
                check("carrier_half", 32'((cyc - tog_cyc) inside {[1041:1042]}), 1);
            end
            tog_cyc = cyc;
        end
        car_q = car_o;
        if (rx_ovr === 1'b1) begin
            ovr_seen++;
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            check("rx_bit", rx_bit, exp_rx.size() ? exp_rx.pop_front() : 2);
        end
        if (sense !== sense_q && rst === 1'b0) begin
            n_tog++;
        end
        sense_q = sense;
    end

    // Receiver stalls at random, and wholly during the buffer-fill stretch
    always @(posedge mclk) begin
        #1 rx_ready = stall ? 1'b0 : 1'($random(seed));
    end

    initial begin
        rst = 1'b1;
        tx_valid = 1'b0;
        tx_bit = 1'b0;
        tx_three = 1'b0;
        rx_ready = 1'b0;
        stall = 1'b0;
        pattern = $random(seed);
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        tx_valid = 1'b1;
        for (int i = 0; i < 30; i++) begin
            @(posedge mclk iff ev === 1'b1);
            #1 tx_bit = 1'($random(seed));
            tx_three = 1'($random(seed));
            repeat (300) @(posedge mclk);
            stall = (i >= 9 && i <= 12);
        end
        repeat (2000) @(posedge mclk);
        check("event_count", n_ev, n_tog);
        check("overrun_count", ovr_seen, ovr_exp);
        check("rx_left", exp_rx.size(), 0);
        check("burst_left", exp_rise.size(), 0);
        wrap_up();
    end

    // Expected run is about 32300 cycles
    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
endmodule
